// file: scb_clkdiv.sv
// Purpose: tick generator for the master serial clock half periods
// Assumes: restart held while the master is idle
// Notes:   one-cycle tick every HALF cycles
`default_nettype none
module scb_clkdiv #(
   parameter int unsigned HALF = 156
) (
   // clock and control
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic ce_i,
   input  wire logic restart_i,
   // tick
   output logic      tick_o
);
   typedef struct packed {
      logic [15:0] cnt;
   } scb_div_st_t;

   scb_div_st_t st;
   scb_div_st_t next_st;

   // ======================================================
   // count down, reload on tick or restart
   always_comb begin
      next_st = st;
      if (restart_i || tick_o) begin
         next_st.cnt = 16'(HALF - 1);
      end else begin
         next_st.cnt = st.cnt - 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st.cnt <= 16'(HALF - 1);
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign tick_o = (st.cnt == 16'h0000) && !restart_i;
endmodule // scb_clkdiv
`default_nettype wire

// file: scb_i2c_slave.sv
// Purpose: behavioural bus slave on the resolved wires
// Assumes: wires already carry their pull-ups
// Notes:   captures the first byte after a start, acks it on command
`default_nettype none
module scb_i2c_slave (
   // bus levels
   input  wire logic  scl_i,
   input  wire logic  sda_i,
   input  wire logic  ack_en_i,
   // drive and capture
   output logic       sda_oe_o,
   output logic [7:0] byte_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 99;
   initial sda_oe_o = 1'h0;
   initial byte_o = 8'h00;
   // ==========================================
   // start: data falls while clock high
   always @(negedge sda_i) begin
      if (scl_i === 1'h1) begin
         cnt = 0;
      end
   end
   // sample on rising clock, first bit is the msb
   always @(posedge scl_i) begin
      if (cnt < 8) begin
         byte_o = {byte_o[6:0], sda_i};
      end
      cnt = cnt + 1;
   end
   // ack only for the ninth clock; released at its falling edge
   always @(negedge scl_i) begin
      sda_oe_o = (cnt == 8) && ack_en_i;
   end
endmodule // scb_i2c_slave
`default_nettype wire

// file: scb_pkg.sv
// Purpose: shared constants and types of the serial bus control block
// Assumes: 125 MHz system clock, 32-bit register bus
// Notes:   offsets are byte addresses of aligned words
`default_nettype none
package scb_pkg;
   // ======================================================
   // clock and link timing
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned SCL_HALF_NS   = 1250;       // master half period
   localparam int unsigned SCL_HALF_CYC  = SCL_HALF_NS / CLK_PERIOD_NS;

   // ======================================================
   // register map
   localparam logic [11:0] OFS_CTRL_STAT = 12'h000;   // control write, status read
   localparam logic [11:0] OFS_IDLE_CTRL = 12'h004;
   localparam logic [11:0] OFS_DATA_BUF  = 12'h008;

   // ======================================================
   // control/status field positions
   localparam int unsigned BIT_MST  = 7;
   localparam int unsigned BIT_TRX  = 6;
   localparam int unsigned BIT_BB   = 5;
   localparam int unsigned BIT_PIN  = 4;
   localparam int unsigned BIT_MODE = 2;              // two bits, 3..2
   localparam int unsigned BIT_SWR  = 0;              // two bits, 1..0
   localparam int unsigned BIT_RUN_IDLE = 6;
   localparam logic [1:0] SWR_ARM_VAL  = 2'h2;
   localparam logic [1:0] SWR_FIRE_VAL = 2'h1;
   localparam logic [7:0] IDLE_FIXED_ONES = 8'hBE;    // bits 7 and 5..1
   localparam logic       PIN_RESET = 1'h1;

   // ======================================================
   // operating modes
   typedef enum logic [1:0] {
      MODE_PORT = 2'h0,
      MODE_SIO  = 2'h1,
      MODE_I2C  = 2'h2,
      MODE_RSVD = 2'h3
   } scb_mode_t;

   // master sequencer states
   typedef enum logic [2:0] {
      M_IDLE, M_START, M_LOW, M_HIGH, M_WAIT, M_STOP_A, M_STOP_B
   } scb_mstate_t;

   // open-drain pin carrier
   typedef struct packed {
      logic scl;
      logic sda;
   } scb_pins_t;

   // engine state of the top module
   typedef struct packed {
      logic        master_select;
      logic        transmit_select;
      logic        bb;
      logic        pin_n;
      logic        al;
      logic        address_match_flag;
      logic        general_call_flag;
      logic        last_bit_received;
      scb_mode_t   mode;
      logic        swr_arm;
      logic        run_idle;
      logic        idle_b0;
      logic [7:0]  tx_buf;
      logic [7:0]  rx_buf;
      logic [7:0]  shreg;
      logic [3:0]  bitcnt;
      logic        first_byte;
      logic        sda_low;
      logic        scl_low;
      logic        scl_prev;
      logic        sda_prev;
      scb_mstate_t mstate;
      logic [31:0] prdata;
   } scb_state_t;
endpackage : scb_pkg
`default_nettype wire

// file: scb_sync.sv
// Purpose: two-flop synchroniser for bus pins
// Assumes: inputs asynchronous to the system clock
// Notes:   first stage feeds only the second stage
`default_nettype none
module scb_sync #(
   parameter int unsigned W = 2
) (
   // clock and control
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   input  wire logic         ce_i,
   // data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] q1;
      logic [W-1:0] q2;
   } scb_sync_st_t;

   scb_sync_st_t st;
   scb_sync_st_t next_st;

   // ======================================================
   // idle bus level is high, so reset to ones
   always_comb begin
      next_st.q1 = d_i;
      next_st.q2 = st.q1;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st <= '1;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign q_o = st.q2;
endmodule // scb_sync
`default_nettype wire

// file: scb_top.sv
// Purpose: control, status, idle and data registers with a small bus engine
// Assumes: APB slave, zero wait states; pins are open drain
// Notes:
// Notes on behaviour
// - control write and status read share one address
// - bit7 master, bit6 transmit, bit5 one starts and zero stops
// - writing one to bit4 clears pending interrupt; zero does nothing
// - mode field 3..2: 00 port, 01 clocked serial, 10 bus mode
// - soft reset only after writing 10 then 01 to bits 1..0
// - status 7..5 show master, transmit and bus busy
// - status bit4 reads zero while interrupt pending, resets to one
// - status 3 arbitration lost, 2 address match, 1 general call
// - general call also sets the address match flag
// - status bit0 holds the last received bus bit
// - idle register bit6 picks stop or run during idle, resets zero
// - idle register bit7 and 5..1 read one; software writes bit0 zero
// - data buffer reads received byte and takes transmit byte
// - transmit sent msb first; received byte lands lsb last
// - data buffer write and read storage are separate
// - free bus, already in bus mode, plus write of 1111 to bits 7..4 starts and sends address
// - stop or arbitration loss clears master and transmit
`default_nettype none
module scb_top
   import scb_pkg::*;
#(
   parameter int unsigned HALF_CYC = SCL_HALF_CYC,
   parameter logic [6:0]  OWN_ADDR = 7'h2A    // arbitrary default slave address
) (
   // clock, reset, enable
   input  wire logic        MCLK_I,
   input  wire logic        RST_B_I,
   input  wire logic        CE_I,
   input  wire logic        IDLE_I,
   // register bus
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // serial bus pins
   input  wire logic        SCL_I,
   output logic             SCL_O,
   output logic             SCL_OE_O,
   input  wire logic        SDA_I,
   output logic             SDA_O,
   output logic             SDA_OE_O,
   // interrupt request level
   output logic             SERIAL_BUS_IRQ_O
);
   localparam scb_state_t ST_RESET = '{
      pin_n: PIN_RESET, mode: MODE_PORT, mstate: M_IDLE,
      scl_prev: 1'h1, sda_prev: 1'h1, default: '0};

   scb_state_t st;
   scb_state_t next_st;
   scb_pins_t  pins_raw;
   scb_pins_t  pins;
   logic       tick;
   logic       div_restart;
   logic       wr_acc;
   logic       rd_setup;
   logic       hit;
   logic       soft_rst;
   logic       run;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic       byte_done;
   logic [7:0] status;
   logic [7:0] wd;

   // ======================================================
   // pin sampling and master clock ticks
   assign pins_raw = '{scl: SCL_I, sda: SDA_I};

   scb_sync #(.W(2)) scb_sync_inst (
      .clk_i   (MCLK_I),
      .rst_b_i (RST_B_I),
      .ce_i    (CE_I),
      .d_i     (pins_raw),
      .q_o     (pins)
   );

   assign div_restart = (st.mstate == M_IDLE) || (st.mstate == M_WAIT);

   scb_clkdiv #(.HALF(HALF_CYC)) scb_clkdiv_inst (
      .clk_i     (MCLK_I),
      .rst_b_i   (RST_B_I),
      .ce_i      (CE_I),
      .restart_i (div_restart),
      .tick_o    (tick)
   );

   // ======================================================
   // bus decode; every access completes in its access cycle
   assign wd       = PWDATA_I[7:0];
   assign wr_acc   = PSEL_I && PENABLE_I && PWRITE_I;
   assign rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
   assign hit      = (PADDR_I == OFS_CTRL_STAT) || (PADDR_I == OFS_IDLE_CTRL)
                     || (PADDR_I == OFS_DATA_BUF);
   assign soft_rst = wr_acc && (PADDR_I == OFS_CTRL_STAT) && st.swr_arm
                     && (wd[BIT_SWR +: 2] == SWR_FIRE_VAL);
   // engine halts in idle unless told to run
   assign run      = !(IDLE_I && !st.run_idle);
   assign status   = {st.master_select, st.transmit_select, st.bb, st.pin_n,
                      st.al, st.address_match_flag, st.general_call_flag, st.last_bit_received};

   // bus events seen through the synchroniser
   assign scl_rise  = pins.scl && !st.scl_prev;
   assign scl_fall  = !pins.scl && st.scl_prev;
   assign start_det = pins.scl && st.scl_prev && st.sda_prev && !pins.sda;
   assign stop_det  = pins.scl && st.scl_prev && !st.sda_prev && pins.sda;
   assign byte_done = scl_rise && (st.bitcnt == 4'h8) && (st.mode == MODE_I2C);

   // ======================================================
   // next state
   always_comb begin
      next_st          = st;
      next_st.scl_prev = pins.scl;
      next_st.sda_prev = pins.sda;

      // read data registered in the setup cycle
      if (rd_setup) begin
         next_st.prdata = 32'h0000_0000;
         case (PADDR_I)
            OFS_CTRL_STAT: next_st.prdata[7:0] = status;
            OFS_IDLE_CTRL: next_st.prdata[7:0] = IDLE_FIXED_ONES
                              | {1'h0, st.run_idle, 5'h00, st.idle_b0};
            OFS_DATA_BUF:  next_st.prdata[7:0] = st.rx_buf;
            default:       next_st.prdata = 32'h0000_0000;
         endcase
      end

      // engine activity
      if (run && st.mode == MODE_I2C) begin
         if (start_det) begin
            next_st.bb         = 1'h1;
            next_st.bitcnt     = 4'h0;
            next_st.first_byte = 1'h1;
            next_st.address_match_flag        = 1'h0;
            next_st.general_call_flag        = 1'h0;
         end
         if (stop_det) begin
            next_st.bb     = 1'h0;
            next_st.master_select    = 1'h0;
            next_st.transmit_select    = 1'h0;
            next_st.mstate = M_IDLE;
            next_st.sda_low = 1'h0;
            next_st.scl_low = 1'h0;
         end
         // drive the next bit after the clock falls
         if (scl_fall && st.bb) begin
            if (st.bitcnt < 4'h8) begin
               next_st.sda_low = st.transmit_select && !st.shreg[7];
            end else begin
               next_st.sda_low = !st.transmit_select && (st.master_select || st.address_match_flag || st.first_byte);
            end
         end
         // sample on the rising clock
         if (scl_rise && st.bb) begin
            next_st.last_bit_received = pins.sda;
            if (st.bitcnt < 4'h8) begin
               next_st.shreg  = {st.shreg[6:0], pins.sda};
               next_st.bitcnt = st.bitcnt + 4'h1;
               if (st.master_select && st.transmit_select && !st.sda_low && !pins.sda && st.mstate == M_HIGH) begin
                  next_st.al      = 1'h1;
                  next_st.master_select     = 1'h0;
                  next_st.transmit_select     = 1'h0;
                  next_st.mstate  = M_IDLE;
                  next_st.sda_low = 1'h0;
                  next_st.scl_low = 1'h0;
               end
            end
         end
         if (byte_done) begin
            next_st.bitcnt     = 4'h0;
            next_st.rx_buf     = st.shreg;
            next_st.pin_n      = 1'h0;
            next_st.first_byte = 1'h0;
            if (st.first_byte && st.master_select && !pins.sda) begin
               next_st.transmit_select = !st.shreg[0];
            end
            if (st.first_byte && !st.master_select) begin
               if (st.shreg == 8'h00) begin
                  next_st.general_call_flag = 1'h1;
                  next_st.address_match_flag = 1'h1;
               end else if (st.shreg[7:1] == OWN_ADDR) begin
                  next_st.address_match_flag = 1'h1;
                  next_st.transmit_select = st.shreg[0];
               end
            end
            if (!st.transmit_select && !(st.first_byte && !st.master_select && st.shreg != 8'h00
                             && st.shreg[7:1] != OWN_ADDR)) begin
               next_st.scl_low = 1'h1;     // stretch until software services it
            end
         end

         // master sequencer
         case (st.mstate)
            M_IDLE: begin
            end
            M_START: if (tick) begin
               next_st.scl_low = 1'h1;
               next_st.mstate  = M_LOW;
            end
            M_LOW: if (tick) begin
               next_st.scl_low = 1'h0;
               next_st.mstate  = M_HIGH;
            end
            M_HIGH: if (tick && pins.scl) begin
               next_st.scl_low = 1'h1;
               next_st.mstate  = (st.bitcnt == 4'h0) ? M_WAIT : M_LOW;
            end
            M_WAIT: begin
            end
            M_STOP_A: if (tick) begin
               next_st.scl_low = 1'h0;
               next_st.mstate  = M_STOP_B;
            end
            M_STOP_B: if (tick) begin
               next_st.sda_low = 1'h0;
               next_st.mstate  = M_IDLE;
            end
            default: next_st.mstate = M_IDLE;
         endcase
      end

      // register writes; hardware sets of the interrupt and loss flags win over software clears
      if (wr_acc) begin
         case (PADDR_I)
            OFS_CTRL_STAT: begin
               next_st.master_select  = wd[BIT_MST];
               next_st.transmit_select  = wd[BIT_TRX];
               next_st.mode = scb_mode_t'(wd[BIT_MODE +: 2]);
               next_st.swr_arm = (wd[BIT_SWR +: 2] == SWR_ARM_VAL);
               if (wd[BIT_PIN] && !byte_done) begin
                  next_st.pin_n = 1'h1;
                  next_st.al    = next_st.al && !st.al;    // a loss in this cycle survives
                  if (st.mstate == M_WAIT) begin
                     next_st.mstate = M_LOW;
                  end
                  if (!st.master_select) begin
                     next_st.scl_low = 1'h0;
                  end
               end
               if (wd[BIT_MST] && wd[BIT_TRX] && wd[BIT_BB] && wd[BIT_PIN]
                   && !st.bb && st.mode == MODE_I2C) begin
                  next_st.shreg   = st.tx_buf;
                  next_st.sda_low = 1'h1;
                  next_st.mstate  = M_START;
               end else if (wd[BIT_MST] && !wd[BIT_BB] && st.master_select && st.bb) begin
                  next_st.sda_low = 1'h1;
                  next_st.scl_low = 1'h1;
                  next_st.mstate  = M_STOP_A;
               end
            end
            OFS_IDLE_CTRL: begin
               next_st.run_idle = wd[BIT_RUN_IDLE];
               next_st.idle_b0  = wd[0];
            end
            OFS_DATA_BUF: begin
               next_st.tx_buf = wd;
               next_st.shreg  = wd;
            end
            default: begin
            end
         endcase
      end

      // port mode releases the pins and parks the engine
      if (next_st.mode != MODE_I2C) begin
         next_st.sda_low = 1'h0;
         next_st.scl_low = 1'h0;
         next_st.mstate  = M_IDLE;
      end
      if (soft_rst) begin
         next_st          = ST_RESET;
         next_st.run_idle = st.run_idle;
         next_st.idle_b0  = st.idle_b0;
      end
   end

   // ======================================================
   // state register
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         st <= ST_RESET;
      end else if (CE_I) begin
         st <= next_st;
      end
   end

   // ======================================================
   // outputs; open drain drives only low
   assign PRDATA_O         = st.prdata;
   assign PREADY_O         = 1'h1;
   assign PSLVERR_O        = PSEL_I && PENABLE_I && !hit;
   assign SCL_O            = 1'h0;
   assign SDA_O            = 1'h0;
   assign SCL_OE_O         = st.scl_low;
   assign SDA_OE_O         = st.sda_low;
   assign SERIAL_BUS_IRQ_O = !st.pin_n;

   // ======================================================
   // checks
   chk_read_status: assert property (@(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
      rd_setup && PADDR_I == OFS_CTRL_STAT |=> PRDATA_O == {24'h0, $past(status)})
      else $error("status read mismatch");
   chk_start_launch: assert property (@(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
      wr_acc && PADDR_I == OFS_CTRL_STAT && wd[7:4] == 4'hF && !st.bb
      && st.mode == MODE_I2C && wd[3:2] == 2'h2 && !soft_rst
      |=> st.mstate == M_START && SDA_OE_O)
      else $error("start not launched");
   chk_pin_zero: assert property (@(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
      wr_acc && PADDR_I == OFS_CTRL_STAT && !wd[BIT_PIN] && !soft_rst
      |=> !$rose(st.pin_n))
      else $error("pin cleared by zero write");
   chk_port_release: assert property (@(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
      st.mode != MODE_I2C |-> !SCL_OE_O && !SDA_OE_O)
      else $error("pins driven outside bus mode");
   chk_soft_reset: assert property (@(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
      soft_rst |=> st.pin_n && !st.bb && st.mode == MODE_PORT ##1 !st.swr_arm)
      else $error("soft reset incomplete");
   chk_stop_clear: assert property (@(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
      stop_det && run && st.mode == MODE_I2C && !wr_acc |=> !st.master_select && !st.transmit_select)
      else $error("stop did not clear role");
   chk_gc_match: assert property (@(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
      st.general_call_flag |-> st.address_match_flag)
      else $error("general call without match");
   chk_idle_ones: assert property (@(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
      rd_setup && PADDR_I == OFS_IDLE_CTRL
      |=> PRDATA_O[7] && PRDATA_O[5:1] == 5'h1F && PRDATA_O[6] == st.run_idle)
      else $error("idle register fixed bits wrong");
   chk_upper_zero: assert property (@(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
      PRDATA_O[31:8] == 24'h0)
      else $error("upper read bits not zero");
endmodule // scb_top
`default_nettype wire

// file: scb_top_tb_top.sv
// Purpose: self-checking bench for the serial bus control block
// Assumes: 125 MHz clock, half period of the serial clock cut to 4
// Notes:   a single slave model; transfers use write direction only
`default_nettype none
module scb_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import scb_pkg::*;
   logic        mclk = 1'h0;
   logic        rst_b = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, scl_oe, sda_oe, irq, s_oe, scl_o, sda_o;
   logic        idle = 1'h0;
   logic        s_ack = 1'h1;
   logic [7:0]  s_byte;
   int          err_total = 0;
   int          n_compared = 0;
   // open-drain wires with pull-ups
   wire logic   scl_w = ~scl_oe;
   wire logic   sda_w = ~(sda_oe | s_oe);

   scb_top #(.HALF_CYC(4)) scb_top_inst (.MCLK_I(mclk), .RST_B_I(rst_b), .CE_I(1'h1),
      .IDLE_I(idle), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda_w),
      .SDA_O(sda_o), .SDA_OE_O(sda_oe), .SERIAL_BUS_IRQ_O(irq));
   scb_i2c_slave scb_i2c_slave_inst (.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(s_ack),
      .sda_oe_o(s_oe), .byte_o(s_byte));

   initial begin
      forever #4 mclk = ~mclk;
   end

   // ==========================================
   // checking and closing
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic logic [31:0] stat(input logic [3:0] hi, input logic last_bit_received);
      return {24'h0, hi, 3'h0, last_bit_received};
   endfunction

   // ==========================================
   // register bus master, entered just after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) begin
         err_total++;
         stop_test();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'h1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'h0, a, 32'h0, r, e);
      chk(r, exp);
   endtask
   // bounded wait for the byte-done request
   task automatic xfer(input logic [7:0] adr);
      int n;
      wr(OFS_DATA_BUF, {8'($urandom), 16'h0, adr});
      wr(OFS_CTRL_STAT, 32'hF8);
      n = 0;
      while (irq !== 1'h1 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 3000) begin
         err_total++;
         stop_test();
      end
      chk({24'h0, s_byte}, {24'h0, adr});
   endtask

   initial begin
      logic [31:0] r;
      logic        e;
      logic        b;
      logic [1:0]  modes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
      void'($urandom(32'hE0C55FED));
      repeat (12) @(posedge mclk);
      rst_b <= 1'h1;
      @(posedge mclk);
      rd(OFS_CTRL_STAT, 32'h10);
      rd(OFS_IDLE_CTRL, 32'hBE);
      rd(OFS_DATA_BUF, 32'h0);
      $display("test reset done");
      // idle register with junk in the upper bits; bit0 kept zero
      repeat (4) begin
         b = 1'($urandom);
         wr(OFS_IDLE_CTRL, {24'($urandom), 1'h0, b, 6'h00});
         rd(OFS_IDLE_CTRL, {24'h0, 1'h1, b, 6'h3E});
      end
      wr(OFS_DATA_BUF, 32'hFFFF_FF5A);
      rd(OFS_DATA_BUF, 32'h0);
      apb(1'h0, 12'h00C, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      $display("test registers done");
      // modes while the bus is free; wires checked high first
      foreach (modes[i]) begin
         chk({30'h0, scl_w, sda_w}, 32'h3);
         wr(OFS_CTRL_STAT, {28'h0, modes[i], 2'h0});
         repeat (4) @(posedge mclk);
         chk({30'h0, scl_oe, sda_oe}, 32'h0);
         rd(OFS_CTRL_STAT, 32'h10);
      end
      $display("test modes done");
      // acked address byte, then stop with request clear
      xfer({7'($urandom), 1'h0});
      rd(OFS_CTRL_STAT, stat(4'hE, 1'h0));
      wr(OFS_CTRL_STAT, 32'hD8);
      repeat (40) begin
         apb(1'h0, OFS_CTRL_STAT, 32'h0, r, e);
         if (r[5] === 1'h0) break;
      end
      chk(r, 32'h10);
      chk({31'h0, irq}, 32'h0);
      $display("test stop done");
      // refused address byte, then soft reset in mid-session
      s_ack <= 1'h0;
      xfer(8'h00);
      rd(OFS_CTRL_STAT, stat(4'hE, 1'h1));
      wr(OFS_CTRL_STAT, 32'hEA);
      rd(OFS_CTRL_STAT, stat(4'hE, 1'h1));
      wr(OFS_CTRL_STAT, 32'hE9);
      repeat (4) @(posedge mclk);
      rd(OFS_CTRL_STAT, 32'h10);
      chk({29'h0, irq, scl_oe, sda_oe}, 32'h0);
      $display("test soft reset done");
      // idle without run-in-idle freezes the engine; registers still answer
      wr(OFS_IDLE_CTRL, 32'h0);
      idle <= 1'h1;
      chk({30'h0, scl_w, sda_w}, 32'h3);
      wr(OFS_CTRL_STAT, 32'h08);
      wr(OFS_DATA_BUF, 32'h0000_00A0);
      wr(OFS_CTRL_STAT, 32'hF8);
      repeat (20) @(posedge mclk);
      chk({30'h0, scl_oe, sda_oe}, 32'h1);
      rd(OFS_CTRL_STAT, 32'hD0);
      wr(OFS_IDLE_CTRL, 32'h40);
      repeat (16) @(posedge mclk);
      chk({30'h0, scl_oe, sda_oe}, 32'h3);
      wr(OFS_CTRL_STAT, 32'h02);
      wr(OFS_CTRL_STAT, 32'h01);
      idle <= 1'h0;
      chk({27'h0, scl_o, sda_o, irq, scl_oe, sda_oe}, 32'h0);
      $display("test idle done");
      stop_test();
   end
endmodule // scb_top_tb_top
`default_nettype wire
